// *** hdl/smfs_top.v ***
// System monitor select and fault status register with data readout
//
// Contract
// (R1) Monitor select lives in system control 09h
// (R2) Select 010 routes temperature sensor
// (R3) Temperature uses programmed gain, inputs disconnected
// (R4) Host keeps gain at most 4
// (R5) Selects 011/100 convert analog/digital supply
// (R6) Supply monitor forces gain one, disconnects inputs
// (R7) Selects 101/110/111 enable burn-out currents
// (R8) Burn-out sources positive, sinks negative input
// (R9) Host disables chop, limits burn-out use
// (R10) Status byte readable at address 01h
// (R11) Send-status bit prefixes status to readout
// (R12) Status read returns last conversion flags
// (R13) Bit 7 set at reset, cleared writing 0
// (R14) Bit 6 shows start-up complete
// (R15) Rail monitors run only when enabled
// (R16) Rail flags occupy status bits 5 to 2
// (R17) Rail faults latched, flags update at end
// (R18) Bypassed amplifier: rails sense converter input
// (R19) Reference-low detection enabled by 05h field
// (R20) Bit 0 below 300 mV, bit 1 third
// (R21) Reference flags update at data-ready fall
// (R22) Host uses pull-together resistor only testing
// (R23) Select 001 connects mid-scale input
// (R24) Data-ready low marks new result
// (R25) Select 000 keeps external inputs connected
`timescale 1ns/1ps
`default_nettype none
`include "smfs_defines.vh"

module smfs_top (
   input  wire        clk_sys_i,
   input  wire        rst_b_i,
   // Register access port
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   output reg         reg_rvalid_o,
   // Conversion timing and result
   input  wire        conv_end_i,
   input  wire [15:0] conv_data_i,
   output reg         data_ready_n_o,
   // Data readout
   input  wire        dout_start_i,
   input  wire        dout_next_i,
   output reg  [7:0]  dout_byte_o,
   output reg         dout_valid_o,
   output reg         dout_last_o,
   // Live monitor comparators
   input  wire        pos_out_high_i,
   input  wire        pos_out_low_i,
   input  wire        neg_out_high_i,
   input  wire        neg_out_low_i,
   input  wire        ref_low_300mv_i,
   input  wire        ref_low_third_i,
   // Analog routing controls
   output wire        ext_inputs_connect_o,
   output wire        midscale_sel_o,
   output wire        temp_sensor_sel_o,
   output wire        analog_supply_sel_o,
   output wire        digital_supply_sel_o,
   output wire        burnout_test_current_en_o,
   output wire [1:0]  burnout_test_current_mag_o,
   output wire [2:0]  effective_gain_o,
   output wire        rail_sense_adc_input_o
);

   localparam integer STARTUP_CYC_INT = `SMFS_STARTUP_CYC;
   localparam [15:0]  STARTUP_CYC     = STARTUP_CYC_INT[15:0];

   localparam [1:0] RD_IDLE   = 2'h0;
   localparam [1:0] RD_STATUS = 2'h1;
   localparam [1:0] RD_MSB    = 2'h2;
   localparam [1:0] RD_LSB    = 2'h3;

   // Configuration bytes
   reg  [7:0]  sysctl_r;
   reg  [7:0]  gain_r;
   reg  [7:0]  refctl_r;
   reg  [7:0]  exc1_r;
   // Status flags and start-up count
   reg         power_on_reset_flag_r;
   reg         ready_r;
   reg  [15:0] startup_cnt_r;
   // Conversion result and readout state
   reg  [15:0] result_r;
   reg  [1:0]  rd_state_r;
   // Combinational next values
   reg  [1:0]  rd_state_nxt;
   reg  [7:0]  rdata_nxt;
   reg  [7:0]  dout_byte_nxt;
   reg         dout_valid_nxt;
   reg         dout_last_nxt;

   // Decoded fields, fault vectors and write strobes
   wire [2:0]  monitor_select;
   wire        send_status_prefix;
   wire        rail_enable;
   wire        ref_enable;
   wire [5:0]  fault_live;
   wire [5:0]  fault_en;
   wire [5:0]  fault_flag;
   wire [7:0]  fault_status_byte;
   wire        wr_ok;
   wire        wr_sysctl;
   wire        wr_gain;
   wire        wr_refctl;
   wire        wr_exc1;
   wire        wr_status;

   assign monitor_select     = sysctl_r[`SMFS_MON_SEL_HI:`SMFS_MON_SEL_LO]; // [R1]
   assign send_status_prefix = sysctl_r[`SMFS_SEND_STATUS_BIT];
   assign rail_enable        = exc1_r[`SMFS_RAIL_EN_BIT];
   assign ref_enable         = |refctl_r[`SMFS_REF_EN_HI:`SMFS_REF_EN_LO];

   // Bit order of the live faults matches the status byte bits 5..0
   assign fault_live = {pos_out_high_i, pos_out_low_i, neg_out_high_i, neg_out_low_i,
                        ref_low_third_i, ref_low_300mv_i}; // [R16] [R20]
   assign fault_en   = {{4{rail_enable}}, {2{ref_enable}}}; // [R15] [R19]

   assign fault_status_byte = {power_on_reset_flag_r, ready_r, fault_flag}; // [R12] [R16] [R20]

   // Configuration is refused until start-up has finished
   assign wr_ok = reg_wr_i && ready_r; // [R14]

   // One write strobe per mapped register
   assign wr_sysctl = wr_ok && (reg_addr_i == `SMFS_ADDR_SYSCTL); // [R1] [R11]
   assign wr_gain   = wr_ok && (reg_addr_i == `SMFS_ADDR_GAIN);
   assign wr_refctl = wr_ok && (reg_addr_i == `SMFS_ADDR_REFCTL); // [R19]
   assign wr_exc1   = wr_ok && (reg_addr_i == `SMFS_ADDR_EXC1); // [R15]
   assign wr_status = wr_ok && (reg_addr_i == `SMFS_ADDR_STATUS); // [R13]

   // Flag accumulators for rails and reference
   smfs_fault_latch u_fault_latch (
      .clk_sys_i    (clk_sys_i),
      .rst_b_i      (rst_b_i),
      .fault_live_i (fault_live),
      .fault_en_i   (fault_en),
      .conv_end_i   (conv_end_i),
      .fault_flag_o (fault_flag)
   );

   // Analog routing decode
   smfs_mux_ctrl u_mux_ctrl (
      .clk_sys_i                  (clk_sys_i),
      .rst_b_i                    (rst_b_i),
      .monitor_select_i           (monitor_select),
      .gain_field_i               (gain_r[`SMFS_GAIN_HI:`SMFS_GAIN_LO]),
      .amplifier_enable_field_i   (gain_r[`SMFS_AMP_EN_HI:`SMFS_AMP_EN_LO]),
      .ext_inputs_connect_o       (ext_inputs_connect_o),
      .midscale_sel_o             (midscale_sel_o),
      .temp_sensor_sel_o          (temp_sensor_sel_o),
      .analog_supply_sel_o        (analog_supply_sel_o),
      .digital_supply_sel_o       (digital_supply_sel_o),
      .burnout_test_current_en_o  (burnout_test_current_en_o),
      .burnout_test_current_mag_o (burnout_test_current_mag_o),
      .effective_gain_o           (effective_gain_o),
      .rail_sense_adc_input_o     (rail_sense_adc_input_o)
   );

   // Start-up counter runs once after reset and stops at its end value
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         startup_cnt_r <= 16'h0000;
      end else if (!ready_r && (startup_cnt_r != STARTUP_CYC - 16'h0001)) begin
         startup_cnt_r <= startup_cnt_r + 16'h0001;
      end
   end

   // Ready flag rises once the count is complete
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ready_r <= 1'b0;
      end else if (startup_cnt_r == STARTUP_CYC - 16'h0001) begin
         ready_r <= 1'b1; // [R14]
      end
   end

   // System control: monitor select and send-status bit
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sysctl_r <= `SMFS_SYSCTL_RST;
      end else if (wr_sysctl) begin
         sysctl_r <= reg_wdata_i; // [R1] [R11]
      end
   end

   // Gain setting: gain code and amplifier enable
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gain_r <= `SMFS_GAIN_RST;
      end else if (wr_gain) begin
         gain_r <= reg_wdata_i;
      end
   end

   // Reference control: reference-low detection enable
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         refctl_r <= `SMFS_REFCTL_RST;
      end else if (wr_refctl) begin
         refctl_r <= reg_wdata_i; // [R19]
      end
   end

   // Excitation current 1: rail monitor enable
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         exc1_r <= `SMFS_EXC1_RST;
      end else if (wr_exc1) begin
         exc1_r <= reg_wdata_i; // [R15]
      end
   end

   // Power-on flag: set by reset, only a written zero clears it
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         power_on_reset_flag_r <= 1'b1; // [R13]
      end else if (wr_status && !reg_wdata_i[`SMFS_ST_POR_BIT]) begin
         power_on_reset_flag_r <= 1'b0; // [R13]
      end
   end

   // Register read path
   always @* begin
      case (reg_addr_i)
         `SMFS_ADDR_STATUS: rdata_nxt = fault_status_byte; // [R10] [R12]
         `SMFS_ADDR_GAIN:   rdata_nxt = gain_r;
         `SMFS_ADDR_REFCTL: rdata_nxt = refctl_r;
         `SMFS_ADDR_EXC1:   rdata_nxt = exc1_r;
         `SMFS_ADDR_SYSCTL: rdata_nxt = sysctl_r;
         default:           rdata_nxt = 8'h00;
      endcase
   end

   // Read valid follows every read strobe by one cycle
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i; // [R10]
      end
   end

   // Read data holds until the next read
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt; // [R10] [R12]
      end
   end

   // Data-ready falls with the flag update, rises when a readout starts
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_ready_n_o <= 1'b1;
      end else if (conv_end_i) begin
         data_ready_n_o <= 1'b0; // [R24] [R21]
      end else if (dout_start_i) begin
         data_ready_n_o <= 1'b1;
      end
   end

   // Result is captured with the conversion end
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_r <= 16'h0000;
      end else if (conv_end_i) begin
         result_r <= conv_data_i;
      end
   end

   // Readout sequencer
   always @* begin
      rd_state_nxt = rd_state_r;
      case (rd_state_r)
         RD_IDLE: begin
            if (dout_start_i) begin
               rd_state_nxt = send_status_prefix ? RD_STATUS : RD_MSB; // [R11]
            end
         end
         RD_STATUS: begin
            if (dout_next_i) begin
               rd_state_nxt = RD_MSB;
            end
         end
         RD_MSB: begin
            if (dout_next_i) begin
               rd_state_nxt = RD_LSB;
            end
         end
         RD_LSB: begin
            if (dout_next_i) begin
               rd_state_nxt = RD_IDLE;
            end
         end
         default: rd_state_nxt = RD_IDLE;
      endcase
   end

   // Byte, valid and last for the state being entered
   always @* begin
      dout_byte_nxt  = 8'h00;
      dout_valid_nxt = 1'b1;
      dout_last_nxt  = 1'b0;
      case (rd_state_nxt)
         RD_STATUS: begin
            dout_byte_nxt = fault_status_byte; // [R11] [R12]
         end
         RD_MSB: begin
            dout_byte_nxt = result_r[15:8];
         end
         RD_LSB: begin
            dout_byte_nxt = result_r[7:0];
            dout_last_nxt = 1'b1;
         end
         default: begin
            dout_valid_nxt = 1'b0;
         end
      endcase
   end

   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_state_r   <= RD_IDLE;
         dout_byte_o  <= 8'h00;
         dout_valid_o <= 1'b0;
         dout_last_o  <= 1'b0;
      end else begin
         rd_state_r   <= rd_state_nxt;
         dout_byte_o  <= dout_byte_nxt;
         dout_valid_o <= dout_valid_nxt;
         dout_last_o  <= dout_last_nxt;
      end
   end

endmodule // smfs_top
`default_nettype wire

// *** hdl/smfs_defines.vh ***
// Register offsets, field positions, reset values and timing counts of the monitor block
`ifndef SMFS_DEFINES_VH
`define SMFS_DEFINES_VH

// Register addresses
`define SMFS_ADDR_STATUS      8'h01
`define SMFS_ADDR_GAIN        8'h03
`define SMFS_ADDR_REFCTL      8'h05
`define SMFS_ADDR_EXC1        8'h06
`define SMFS_ADDR_SYSCTL      8'h09

// Field positions
`define SMFS_MON_SEL_HI       7
`define SMFS_MON_SEL_LO       5
`define SMFS_SEND_STATUS_BIT  0
`define SMFS_GAIN_HI          2
`define SMFS_GAIN_LO          0
`define SMFS_AMP_EN_HI        4
`define SMFS_AMP_EN_LO        3
`define SMFS_REF_EN_HI        7
`define SMFS_REF_EN_LO        6
`define SMFS_RAIL_EN_BIT      7
`define SMFS_ST_POR_BIT       7
`define SMFS_ST_RDY_BIT       6

// Reset values
`define SMFS_GAIN_RST         8'h00
`define SMFS_REFCTL_RST       8'h00
`define SMFS_EXC1_RST         8'h00
`define SMFS_SYSCTL_RST       8'h00

// Monitor select codes, unity gain code and amplifier bypass code
`define SMFS_MON_OFF          3'h0
`define SMFS_MON_MID          3'h1
`define SMFS_MON_TEMP         3'h2
`define SMFS_MON_AVDD         3'h3
`define SMFS_MON_DVDD         3'h4
`define SMFS_MON_BO_LOW       3'h5
`define SMFS_MON_BO_MID       3'h6
`define SMFS_MON_BO_HIGH      3'h7
`define SMFS_GAIN_ONE         3'h0
`define SMFS_PGA_BYPASS       2'h0

// Start-up time before the ready flag rises
`define SMFS_CLK_PERIOD_NS    20
`define SMFS_STARTUP_NS       2000
`define SMFS_STARTUP_CYC      ((`SMFS_STARTUP_NS + `SMFS_CLK_PERIOD_NS - 1) / `SMFS_CLK_PERIOD_NS)

`endif

// *** hdl/smfs_mux_ctrl.v ***
// Decode of the monitor select field into analog routing controls
`timescale 1ns/1ps
`default_nettype none
`include "smfs_defines.vh"

module smfs_mux_ctrl (
   input  wire       clk_sys_i,
   input  wire       rst_b_i,
   input  wire [2:0] monitor_select_i,
   input  wire [2:0] gain_field_i,
   input  wire [1:0] amplifier_enable_field_i,
   output reg        ext_inputs_connect_o,
   output reg        midscale_sel_o,
   output reg        temp_sensor_sel_o,
   output reg        analog_supply_sel_o,
   output reg        digital_supply_sel_o,
   output reg        burnout_test_current_en_o,
   output reg  [1:0] burnout_test_current_mag_o,
   output reg  [2:0] effective_gain_o,
   output reg        rail_sense_adc_input_o
);

   wire supply_sel;

   assign supply_sel = (monitor_select_i == `SMFS_MON_AVDD) ||
                       (monitor_select_i == `SMFS_MON_DVDD);

   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ext_inputs_connect_o       <= 1'b1;
         midscale_sel_o             <= 1'b0;
         temp_sensor_sel_o          <= 1'b0;
         analog_supply_sel_o        <= 1'b0;
         digital_supply_sel_o       <= 1'b0;
         burnout_test_current_en_o  <= 1'b0;
         burnout_test_current_mag_o <= 2'h0;
         effective_gain_o           <= `SMFS_GAIN_ONE;
         rail_sense_adc_input_o     <= 1'b1;
      end else begin
         // Off and burn-out settings keep the external pair on the converter
         ext_inputs_connect_o <= (monitor_select_i == `SMFS_MON_OFF) ||
                                 monitor_select_i[2] && (monitor_select_i != `SMFS_MON_DVDD); // [R25] [R3] [R6]
         midscale_sel_o       <= (monitor_select_i == `SMFS_MON_MID);  // [R23]
         temp_sensor_sel_o    <= (monitor_select_i == `SMFS_MON_TEMP); // [R2] [R3]
         analog_supply_sel_o  <= (monitor_select_i == `SMFS_MON_AVDD); // [R5]
         digital_supply_sel_o <= (monitor_select_i == `SMFS_MON_DVDD); // [R5]
         // Source into the positive input, sink equally from the negative one
         burnout_test_current_en_o <= monitor_select_i[2] &&
                                      (monitor_select_i != `SMFS_MON_DVDD); // [R7] [R8]
         case (monitor_select_i)
            `SMFS_MON_BO_LOW:  burnout_test_current_mag_o <= 2'h1; // [R7]
            `SMFS_MON_BO_MID:  burnout_test_current_mag_o <= 2'h2; // [R7]
            `SMFS_MON_BO_HIGH: burnout_test_current_mag_o <= 2'h3; // [R7]
            default:           burnout_test_current_mag_o <= 2'h0;
         endcase
         // Temperature uses the programmed gain, supplies force unity gain
         effective_gain_o <= supply_sel ? `SMFS_GAIN_ONE : gain_field_i; // [R6] [R3]
         rail_sense_adc_input_o <= (amplifier_enable_field_i == `SMFS_PGA_BYPASS); // [R18]
      end
   end

endmodule // smfs_mux_ctrl
`default_nettype wire

// *** hdl/smfs_fault_latch.v ***
// Per-flag fault accumulators updated once per conversion end
`timescale 1ns/1ps
`default_nettype none

module smfs_fault_latch (
   input  wire       clk_sys_i,
   input  wire       rst_b_i,
   input  wire [5:0] fault_live_i,
   input  wire [5:0] fault_en_i,
   input  wire       conv_end_i,
   output wire [5:0] fault_flag_o
);

   reg  [5:0] acc_r;
   reg  [5:0] flag_r;

   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1) begin : g_flag
         always @(posedge clk_sys_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               acc_r[i]  <= 1'b0;
               flag_r[i] <= 1'b0;
            end else if (conv_end_i) begin
               // A fault seen in the last cycle still counts
               flag_r[i] <= fault_en_i[i] & (acc_r[i] | fault_live_i[i]); // [R17] [R21] [R15] [R19]
               acc_r[i]  <= 1'b0;
            end else if (fault_en_i[i] && fault_live_i[i]) begin
               acc_r[i]  <= 1'b1; // [R17] [R21]
            end
         end
      end
   endgenerate

   assign fault_flag_o = flag_r;

endmodule // smfs_fault_latch
`default_nettype wire

// *** tb/smfs_host_model.sv ***
// Host controller model driving the register port of the monitor block
`timescale 1ns/1ps
`default_nettype none
module smfs_host_model (
   input  wire logic       clk_sys_i,
   output var  logic       reg_wr_o,
   output var  logic       reg_rd_o,
   output var  logic [7:0] reg_addr_o,
   output var  logic [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       reg_rvalid_i
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // Gain stays at 4 or below, chop and pull-together resistor never used
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
      @(negedge clk_sys_i);
      {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b0, ~a, ~d};
   endtask
   // Read data is taken while the one-cycle valid pulse stands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_i);
      {reg_rd_o, reg_addr_o} = {1'b1, a};
      @(negedge clk_sys_i);
      {reg_rd_o, reg_addr_o} = {1'b0, ~a};
      d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
   endtask
endmodule // smfs_host_model
`default_nettype wire

// *** tb/smfs_top_sva.sv ***
// Port-level assertions for the monitor select and fault status block
`timescale 1ns/1ps
`default_nettype none
module smfs_top_sva (
   input wire logic       clk_sys_i,
   input wire logic       rst_b_i,
   input wire logic       reg_rd_i,
   input wire logic       reg_rvalid_o,
   input wire logic       conv_end_i,
   input wire logic       data_ready_n_o,
   input wire logic       dout_start_i,
   input wire logic       dout_valid_o,
   input wire logic       dout_last_o,
   input wire logic       ext_inputs_connect_o,
   input wire logic       midscale_sel_o,
   input wire logic       temp_sensor_sel_o,
   input wire logic       analog_supply_sel_o,
   input wire logic       digital_supply_sel_o,
   input wire logic       burnout_test_current_en_o,
   input wire logic [1:0] burnout_test_current_mag_o,
   input wire logic [2:0] effective_gain_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   AST_RVALID: assert property (reg_rvalid_o == $past(reg_rd_i))
      else $error("read valid not one cycle after read");
   AST_READY_N_FALL: assert property (conv_end_i |=> !data_ready_n_o)
      else $error("data ready not low after conversion end");
   AST_READY_N_HOLD: assert property (!data_ready_n_o && !dout_start_i
      |=> !data_ready_n_o)
      else $error("data ready rose without readout");
   AST_RDOUT_START: assert property (dout_start_i && !dout_valid_o && !conv_end_i
      |=> dout_valid_o && data_ready_n_o)
      else $error("readout did not start");
   AST_LAST: assert property (dout_last_o |-> dout_valid_o)
      else $error("last byte flagged without valid");
   AST_ONE_ROUTE: assert property ($onehot0({midscale_sel_o, temp_sensor_sel_o,
      analog_supply_sel_o, digital_supply_sel_o, burnout_test_current_en_o}))
      else $error("more than one monitor route");
   AST_TEMP: assert property (temp_sensor_sel_o |-> !ext_inputs_connect_o)
      else $error("inputs connected during temperature");
   AST_SUPPLY: assert property (analog_supply_sel_o || digital_supply_sel_o
      |-> effective_gain_o == 3'h0 && !ext_inputs_connect_o)
      else $error("supply monitor gain or inputs wrong");
   AST_MID: assert property (midscale_sel_o |-> !ext_inputs_connect_o)
      else $error("inputs connected during mid-scale");
   AST_BURN: assert property (burnout_test_current_en_o
      |-> burnout_test_current_mag_o != 2'h0 && ext_inputs_connect_o)
      else $error("burn-out current setting wrong");
   AST_EXT: assert property (ext_inputs_connect_o |-> !(midscale_sel_o ||
      temp_sensor_sel_o || analog_supply_sel_o || digital_supply_sel_o))
      else $error("inputs connected with internal route");
   COV_CONV: cover property (conv_end_i ##1 !data_ready_n_o);
   COV_LAST: cover property (dout_last_o);
   COV_TEMP: cover property (temp_sensor_sel_o);
endmodule // smfs_top_sva
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the monitor select and fault status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        conv_end_i = 1'b0, dout_start_i = 1'b0, dout_next_i = 1'b0;
   logic [15:0] conv_data_i = 16'h0000;
   logic [5:0]  fault = 6'h00;
   wire         reg_wr_i, reg_rd_i, reg_rvalid_o, data_ready_n_o, dout_valid_o, dout_last_o;
   wire  [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, dout_byte_o;
   wire         ext_inputs_connect_o, midscale_sel_o, temp_sensor_sel_o, analog_supply_sel_o;
   wire         digital_supply_sel_o, burnout_test_current_en_o, rail_sense_adc_input_o;
   wire  [1:0]  burnout_test_current_mag_o;
   wire  [2:0]  effective_gain_o;
   wire         pos_out_high_i = fault[5], pos_out_low_i = fault[4];
   wire         neg_out_high_i = fault[3], neg_out_low_i = fault[2];
   wire         ref_low_third_i = fault[1], ref_low_300mv_i = fault[0];
   integer      mismatches = 0, n_checks = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   smfs_top u_smfs_top (.*);
   smfs_host_model u_smfs_host_model (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i),
      .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_smfs_host_model.rd(a, d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_smfs_host_model.wr(a, d);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic pulse_conv;
      conv_end_i = 1'b1;
      cycles(1);
      conv_end_i = 1'b0;
      chk({7'h0, data_ready_n_o}, 8'h00);
   endtask
   // Fault is live for one cycle well before the conversion end
   task automatic convert(input logic [5:0] f);
      fault = f;
      cycles(1);
      fault = 6'h00;
      cycles(2);
      pulse_conv;
   endtask
   task automatic t_startup;
      rd_chk(8'h01, 8'h80);
      wr(8'h09, 8'h40);
      cycles(110);
      chk({7'h0, temp_sensor_sel_o}, 8'h00);
      rd_chk(8'h01, 8'hc0);
      wr(8'h01, 8'hff);
      rd_chk(8'h01, 8'hc0);
      wr(8'h01, 8'h7f);
      rd_chk(8'h01, 8'h40);
   endtask
   task automatic t_select;
      logic [2:0] s;
      wr(8'h03, 8'h0a);
      for (int i = 0; i < 8; i++) begin
         s = i[2:0];
         wr(8'h09, {s, 5'h00});
         cycles(2);
         chk({ext_inputs_connect_o, midscale_sel_o, temp_sensor_sel_o, analog_supply_sel_o,
            digital_supply_sel_o, burnout_test_current_en_o, burnout_test_current_mag_o},
            {s == 3'h0 || s > 3'h4, s == 3'h1, s == 3'h2, s == 3'h3, s == 3'h4, s > 3'h4,
            s > 3'h4 ? s[1:0] : 2'h0});
         chk({5'h0, effective_gain_o}, (s == 3'h3 || s == 3'h4) ? 8'h00 : 8'h02);
      end
      wr(8'h03, 8'h02);
      cycles(2);
      chk({7'h0, rail_sense_adc_input_o}, 8'h01);
      wr(8'h03, 8'h0a);
      cycles(2);
      chk({7'h0, rail_sense_adc_input_o}, 8'h00);
      wr(8'h09, 8'h00);
   endtask
   task automatic t_rail;
      wr(8'h06, 8'h80);
      for (int b = 2; b < 6; b++) begin
         convert(6'h01 << b);
         rd_chk(8'h01, 8'h40 | (8'h01 << b));
      end
      convert(6'h00);
      fault = 6'h3c;
      rd_chk(8'h01, 8'h40);
      pulse_conv;
      fault = 6'h00;
      rd_chk(8'h01, 8'h7c);
      convert(6'h00);
      rd_chk(8'h01, 8'h40);
      wr(8'h06, 8'h00);
      convert(6'h3c);
      rd_chk(8'h01, 8'h40);
   endtask
   task automatic t_ref;
      wr(8'h05, 8'hc0);
      convert(6'h03);
      rd_chk(8'h01, 8'h43);
      convert(6'h01);
      rd_chk(8'h01, 8'h41);
      wr(8'h05, 8'h00);
      convert(6'h03);
      rd_chk(8'h01, 8'h40);
   endtask
   task automatic readout(input int n, input logic [23:0] bytes);
      dout_start_i = 1'b1;
      cycles(1);
      dout_start_i = 1'b0;
      chk({7'h0, data_ready_n_o}, 8'h01);
      for (int k = 0; k < n; k++) begin
         chk({6'h0, dout_valid_o, dout_last_o}, {7'h01, k == n - 1});
         chk(dout_byte_o, bytes[23 - 8 * k -: 8]);
         dout_next_i = 1'b1;
         cycles(1);
         dout_next_i = 1'b0;
      end
      chk({7'h0, dout_valid_o}, 8'h00);
   endtask
   task automatic t_readout;
      wr(8'h05, 8'hc0);
      wr(8'h09, 8'h01);
      conv_data_i = 16'hbe5a;
      convert(6'h01);
      readout(3, 24'h41be5a);
      wr(8'h09, 8'h00);
      conv_data_i = 16'h1234;
      convert(6'h00);
      readout(2, 24'h123400);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      cycles(5);
      rst_b_i = 1'b1;
      t_startup;
      t_select;
      t_rail;
      t_ref;
      t_readout;
      tally_and_finish;
   end
   initial begin
      #200000;
      mismatches++;
      tally_and_finish;
   end
endmodule // testbench

bind smfs_top smfs_top_sva u_smfs_top_sva (.*);
`default_nettype wire
